//--- rtl/cppm_ctrl.sv
// Power-mode state machine and cell protection logic.
`default_nettype none

// Overview of operation
// - Measurement and monitoring run only in active; all stop in sleep.
// - Disconnect-sleep enabled and host line low over 2 s enters sleep.
// - Cell below undervoltage threshold for full delay enters sleep.
// - Pack-swap command with swap enable set enters sleep.
// - Disconnect-sleep enabled, swap disabled, host line high wakes device.
// - Power switch input low wakes the device from sleep.
// - Swap disabled and pack terminal above cell wakes device; with undervoltage flag set, supply must also be above 2.2 V.
// - Pack-swap command with swap enable set returns to active.
// - After power-up the device starts in sleep.
// - Protection conditions are evaluated only while active.
// - Overvoltage held past delay turns charge off and sets its flag.
// - Overvoltage releases when cell falls below charge-enable threshold.
// - Undervoltage past delay turns both off, sets flag, sleeps.
// - Undervoltage releases on pack above supply, supply above 2.2 V.
// - Recovery charge path enabled only while supply below about 3 V.
// - Charge overcurrent past delay turns both off, sets its flag.
// - Charge overcurrent pulls terminal down; releases below test offset.
// - Discharge overcurrent past delay turns discharge off, sets flag.
// - Discharge overcurrent pulls terminal up; releases above test offset.
// - Short circuit past delay turns discharge off, sets discharge flag.
// - Short circuit pulls terminal up; releases above test offset.
// - Gate controls are the OR of their blocking conditions and sleep.
module cppm_ctrl
  import cppm_pkg::*;
#(
  parameter int unsigned CNT_W    = CNT_W_DEF,
  parameter int unsigned DISC_CYC = DISC_SLEEP_CYC,
  parameter int unsigned OV_CYC   = OV_DLY_CYC,
  parameter int unsigned UV_CYC   = UV_DLY_CYC,
  parameter int unsigned OC_CYC   = OC_DLY_CYC,
  parameter int unsigned SC_CYC   = SC_DLY_CYC
) (
  input  wire logic        clk_sys,             // System clock, 40 MHz.
  input  wire logic        reset,               // Synchronous reset, high.
  input  wire cppm_cmp_t   cmp,                 // Comparator results.
  input  wire logic        host_data_line,      // Host data line level.
  input  wire logic        power_switch_n,      // Power switch, low = wake.
  input  wire logic        swap_cmd,            // Pack-swap command pulse.
  input  wire logic        disconnect_sleep_en, // Disconnect sleep enable.
  input  wire logic        swap_enable,         // Swap enable bit.
  input  wire logic        charge_enable_bit,   // Host charge enable.
  input  wire logic        discharge_enable_bit,// Host discharge enable.
  output logic             charge_ctrl_n,       // Charge gate, high = off.
  output logic             discharge_ctrl_n,    // Discharge gate, high = off.
  output cppm_flags_t      flags,               // Protection flags.
  output logic             active_mode,         // High while active.
  output logic             measure_en,          // Measurement enable.
  output logic             recovery_charge_en,  // Recovery charge path on.
  output logic             test_pull_down_en,   // Terminal pull-down on.
  output logic             test_pull_up_en      // Terminal pull-up on.
);

  // ---------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 31)
    $error("CNT_W out of range");
  if (DISC_CYC < 1 || DISC_CYC >= (1 << CNT_W) ||
      OV_CYC < 1 || OV_CYC >= (1 << CNT_W) ||
      UV_CYC < 1 || UV_CYC >= (1 << CNT_W) ||
      OC_CYC < 1 || OC_CYC >= (1 << CNT_W) ||
      SC_CYC < 1 || SC_CYC >= (1 << CNT_W))
    $error("Delay count does not fit CNT_W");

  localparam logic [CNT_W-1:0] DISC_LIM = CNT_W'(DISC_CYC);
  localparam logic [CNT_W-1:0] OV_LIM   = CNT_W'(OV_CYC);
  localparam logic [CNT_W-1:0] UV_LIM   = CNT_W'(UV_CYC);
  localparam logic [CNT_W-1:0] OC_LIM   = CNT_W'(OC_CYC);
  localparam logic [CNT_W-1:0] SC_LIM   = CNT_W'(SC_CYC);

  // Next value of a delay counter; it saturates at its limit.
  function automatic logic [CNT_W-1:0] dly_next(
    input logic             run,
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lim
  );
    if (!run)
      return '0;
    else if (cnt == lim)
      return cnt;
    else
      return cnt + CNT_W'(1);
  endfunction

  // ---------------------------------------------------------------------
  // State and storage
  // ---------------------------------------------------------------------
  cppm_state_t      state_r;
  cppm_state_t      state_nxt;
  logic [CNT_W-1:0] disc_cnt_r;
  logic [CNT_W-1:0] ov_cnt_r;
  logic [CNT_W-1:0] uv_cnt_r;
  logic [CNT_W-1:0] coc_cnt_r;
  logic [CNT_W-1:0] doc_cnt_r;
  logic [CNT_W-1:0] sc_cnt_r;
  logic             ov_r;
  logic             uv_r;
  logic             coc_r;
  logic             doc_r;
  logic             ov_nxt;
  logic             uv_nxt;
  logic             coc_nxt;
  logic             doc_nxt;
  logic             act;
  logic             disc_run;
  logic             disc_trip;
  logic             ov_trip;
  logic             uv_trip;
  logic             coc_trip;
  logic             doc_trip;
  logic             sc_trip;
  logic             go_sleep;
  logic             wake;

  assign act = (state_r == CPPM_ACTIVE);

  // ---------------------------------------------------------------------
  // Delay counters
  // ---------------------------------------------------------------------
  assign disc_run = act && disconnect_sleep_en && !host_data_line;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      disc_cnt_r <= '0;
      ov_cnt_r   <= '0;
      uv_cnt_r   <= '0;
      coc_cnt_r  <= '0;
      doc_cnt_r  <= '0;
      sc_cnt_r   <= '0;
    end else begin
      disc_cnt_r <= dly_next(disc_run, disc_cnt_r, DISC_LIM);
      ov_cnt_r   <= dly_next(act && cmp.cell_over_ov, ov_cnt_r, OV_LIM);
      uv_cnt_r   <= dly_next(act && cmp.cell_below_uv, uv_cnt_r, UV_LIM);
      coc_cnt_r  <= dly_next(act && cmp.sense_over_oc, coc_cnt_r, OC_LIM);
      doc_cnt_r  <= dly_next(act && cmp.sense_below_neg_oc, doc_cnt_r,
                             OC_LIM);
      sc_cnt_r   <= dly_next(act && cmp.sense_node_over_sc, sc_cnt_r,
                             SC_LIM);
    end
  end

  // A trip needs the condition on the cycle after the full count.
  // disconnect timer trip
  assign disc_trip = disc_run && (disc_cnt_r == DISC_LIM);
  assign ov_trip   = act && cmp.cell_over_ov && (ov_cnt_r == OV_LIM);
  assign uv_trip   = act && cmp.cell_below_uv && (uv_cnt_r == UV_LIM);
  assign coc_trip  = act && cmp.sense_over_oc && (coc_cnt_r == OC_LIM);
  assign doc_trip  = act && cmp.sense_below_neg_oc &&
                     (doc_cnt_r == OC_LIM);
  assign sc_trip   = act && cmp.sense_node_over_sc && (sc_cnt_r == SC_LIM);

  // ---------------------------------------------------------------------
  // Protection flags
  // ---------------------------------------------------------------------
  // A trip in the same cycle as its release keeps the flag set.
  always_comb begin
    ov_nxt  = ov_r;
    uv_nxt  = uv_r;
    coc_nxt = coc_r;
    doc_nxt = doc_r;
    if (cmp.cell_below_ce)
      ov_nxt = 1'b0;
    if (cmp.pack_above_supply && cmp.supply_above_2v2)
      uv_nxt = 1'b0;
    if (cmp.pack_below_tp)
      coc_nxt = 1'b0;
    if (cmp.pack_above_tp)
      doc_nxt = 1'b0;
    if (ov_trip)
      ov_nxt = 1'b1;
    if (uv_trip)
      uv_nxt = 1'b1;
    if (coc_trip)
      coc_nxt = 1'b1;
    if (doc_trip || sc_trip)
      doc_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ov_r  <= FLAG_RST;
      uv_r  <= FLAG_RST;
      coc_r <= FLAG_RST;
      doc_r <= FLAG_RST;
    end else begin
      ov_r  <= ov_nxt;
      uv_r  <= uv_nxt;
      coc_r <= coc_nxt;
      doc_r <= doc_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Power mode
  // ---------------------------------------------------------------------
  // sleep entry: disconnect, undervoltage or swap
  assign go_sleep = disc_trip || uv_trip || (swap_cmd && swap_enable);

  // A charger wake with the undervoltage flag set waits for supply above 2.2 V.
  // wake: host connect, power switch, charger or swap
  assign wake = (disconnect_sleep_en && !swap_enable && host_data_line) ||
                !power_switch_n ||
                (!swap_enable && cmp.pack_above_cell &&
                 (!uv_r || cmp.supply_above_2v2)) ||
                (swap_cmd && swap_enable);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CPPM_ACTIVE: begin
        if (go_sleep)
          state_nxt = CPPM_SLEEP;
      end
      CPPM_SLEEP: begin
        if (wake)
          state_nxt = CPPM_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset)
      state_r <= CPPM_SLEEP;
    else
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // gate control OR
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      charge_ctrl_n    <= CTRL_N_RST;
      discharge_ctrl_n <= CTRL_N_RST;
    end else begin
      charge_ctrl_n    <= (state_nxt == CPPM_SLEEP) || ov_nxt || uv_nxt ||
                          coc_nxt || !charge_enable_bit;
      discharge_ctrl_n <= (state_nxt == CPPM_SLEEP) || uv_nxt ||
                          coc_nxt || doc_nxt || !discharge_enable_bit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      active_mode        <= 1'b0;
      measure_en         <= 1'b0;
      recovery_charge_en <= 1'b0;
      test_pull_down_en  <= 1'b0;
      test_pull_up_en    <= 1'b0;
    end else begin
      active_mode        <= (state_nxt == CPPM_ACTIVE);
      measure_en         <= (state_nxt == CPPM_ACTIVE);
      recovery_charge_en <= uv_nxt && cmp.supply_below_3v;
      test_pull_down_en  <= coc_nxt;
      test_pull_up_en    <= doc_nxt;
    end
  end

  assign flags = '{overvoltage_flag:           ov_r,
                   undervoltage_flag:          uv_r,
                   charge_overcurrent_flag:    coc_r,
                   discharge_overcurrent_flag: doc_r};

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_pwr_up_sleep;
    @(posedge clk_sys) $fell(reset) |-> !active_mode && charge_ctrl_n &&
      discharge_ctrl_n;
  endproperty
  a_pwr_up_sleep: assert property (p_pwr_up_sleep)
    else $error("Not in sleep after reset");

  property p_sleep_gates;
    @(posedge clk_sys) disable iff (reset)
      !active_mode |-> charge_ctrl_n && discharge_ctrl_n && !measure_en;
  endproperty
  a_sleep_gates: assert property (p_sleep_gates)
    else $error("Gate on or measuring in sleep");

  property p_disc_sleep;
    @(posedge clk_sys) disable iff (reset)
      act && disconnect_sleep_en && !host_data_line &&
      disc_cnt_r == DISC_LIM |=> !active_mode;
  endproperty
  a_disc_sleep: assert property (p_disc_sleep)
    else $error("Disconnect timeout did not sleep");

  property p_ps_wake;
    @(posedge clk_sys) disable iff (reset)
      !act && !power_switch_n |=> active_mode ##0 !discharge_ctrl_n ||
      !discharge_enable_bit || uv_r || coc_r || doc_r;
  endproperty
  a_ps_wake: assert property (p_ps_wake)
    else $error("Power switch did not wake");

  property p_ov_trip;
    @(posedge clk_sys) disable iff (reset)
      $rose(ov_r) |-> $past(cmp.cell_over_ov) && charge_ctrl_n;
  endproperty
  a_ov_trip: assert property (p_ov_trip)
    else $error("Overvoltage flag without cause");

  property p_ov_release;
    @(posedge clk_sys) disable iff (reset)
      $fell(ov_r) |-> $past(cmp.cell_below_ce);
  endproperty
  a_ov_release: assert property (p_ov_release)
    else $error("Overvoltage released early");

  property p_uv_sleep;
    @(posedge clk_sys) disable iff (reset)
      $rose(uv_r) |-> !act && charge_ctrl_n && discharge_ctrl_n;
  endproperty
  a_uv_sleep: assert property (p_uv_sleep)
    else $error("Undervoltage did not sleep");

  property p_recovery;
    @(posedge clk_sys) disable iff (reset)
      recovery_charge_en |-> $past(uv_nxt) && $past(cmp.supply_below_3v);
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("Recovery path outside window");

  property p_coc_hold;
    @(posedge clk_sys) disable iff (reset)
      coc_r |=> test_pull_down_en || $past(cmp.pack_below_tp);
  endproperty
  a_coc_hold: assert property (p_coc_hold)
    else $error("Pull-down missing during charge overcurrent");

  property p_doc_gate;
    @(posedge clk_sys) disable iff (reset)
      doc_r |-> discharge_ctrl_n && test_pull_up_en;
  endproperty
  a_doc_gate: assert property (p_doc_gate)
    else $error("Discharge on during discharge fault");

endmodule : cppm_ctrl
`default_nettype wire

//--- rtl/cppm_pkg.sv
// Constants and carrier types for the cell protection power-mode controller.
`default_nettype none
package cppm_pkg;

  // ---------------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned CLK_PER_MS       = CLK_HZ / 1000;

  // ---------------------------------------------------------------------
  // Timing constants
  // ---------------------------------------------------------------------
  // Host data line low time before a disconnect sleep, in ms.
  localparam int unsigned DISC_SLEEP_MS    = 2000;
  localparam int unsigned DISC_SLEEP_CYC   = DISC_SLEEP_MS * CLK_PER_MS;
  // Protection delays in cycles; plain defaults for the adjustable part.
  localparam int unsigned OV_DLY_CYC       = 4000;
  localparam int unsigned UV_DLY_CYC       = 4000;
  localparam int unsigned OC_DLY_CYC       = 400;
  localparam int unsigned SC_DLY_CYC       = 8;
  localparam int unsigned CNT_W_DEF        = 27;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic        CTRL_N_RST       = 1'b1;
  localparam logic        FLAG_RST         = 1'b0;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic {
    CPPM_SLEEP  = 1'b0,
    CPPM_ACTIVE = 1'b1
  } cppm_state_t;

  // Comparator results, all active high, synchronous to clk_sys.
  typedef struct packed {
    logic cell_over_ov;        // Cell above overvoltage threshold.
    logic cell_below_uv;       // Cell below undervoltage_threshold.
    logic cell_below_ce;       // Cell below charge_enable_threshold.
    logic sense_over_oc;       // Filtered sense above overcurrent_threshold.
    logic sense_below_neg_oc;  // Filtered sense below negative threshold.
    logic sense_node_over_sc;  // sense_node above short_circuit_threshold.
    logic pack_above_cell;     // pack_terminal above cell_voltage_in.
    logic pack_above_supply;   // pack_terminal above supply.
    logic pack_below_tp;       // pack_terminal below supply - offset.
    logic pack_above_tp;       // pack_terminal above supply - offset.
    logic supply_above_2v2;    // Supply above 2.2 V.
    logic supply_below_3v;     // Supply below about 3 V.
  } cppm_cmp_t;

  typedef struct packed {
    logic overvoltage_flag;
    logic undervoltage_flag;
    logic charge_overcurrent_flag;
    logic discharge_overcurrent_flag;
  } cppm_flags_t;

endpackage : cppm_pkg
`default_nettype wire

//--- sim/cppm_cell_model.sv
// Behavioural cell, pack terminal and comparator model for the controller.
`default_nettype none
module cppm_cell_model
  import cppm_pkg::*;
#(
  parameter logic signed [15:0] OV_MV  = 16'sh10cc, // Overvoltage, mV.
  parameter logic signed [15:0] CE_MV  = 16'sh1004, // Charge enable, mV.
  parameter logic signed [15:0] UV_MV  = 16'sh09c4, // Undervoltage, mV.
  parameter logic signed [15:0] OC_UV  = 16'sh1388, // Overcurrent, uV.
  parameter logic signed [15:0] SC_MV  = 16'sh00c8, // Short circuit, mV.
  parameter logic signed [15:0] TP_MV  = 16'sh01f4  // Test-point offset.
) (
  input  wire logic signed [15:0] cell_mv,           // Cell voltage, mV.
  input  wire logic signed [15:0] supply_mv,         // Supply, mV.
  input  wire logic signed [15:0] sense_uv,          // Filtered sense, uV.
  input  wire logic signed [15:0] node_mv,           // Sense node, mV.
  input  wire logic               charger,           // Charger attached.
  input  wire logic               load,              // Heavy load attached.
  input  wire logic               discharge_ctrl_n,  // Discharge gate.
  input  wire logic               test_pull_down_en, // Terminal pull-down.
  input  wire logic               test_pull_up_en,   // Terminal pull-up.
  output var  cppm_cmp_t          cmp                // Comparator levels.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic signed [15:0] pack_mv;

  // ---------------------------------------------------------------------
  // Pack terminal
  // ---------------------------------------------------------------------
  // terminal test currents
  always_comb begin
    if (charger) begin
      pack_mv = supply_mv + 16'sh012c;
    end else if (load) begin
      pack_mv = discharge_ctrl_n ? 16'sh0000 : cell_mv - 16'sh0032;
    end else if (test_pull_down_en) begin
      pack_mv = 16'sh0000;
    end else if (test_pull_up_en || !discharge_ctrl_n) begin
      pack_mv = supply_mv;
    end else begin
      pack_mv = 16'sh0000;
    end
  end

  // ---------------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------------
  always_comb begin
    cmp.cell_over_ov       = cell_mv > OV_MV;
    cmp.cell_below_uv      = cell_mv < UV_MV;
    cmp.cell_below_ce      = cell_mv < CE_MV;
    cmp.sense_over_oc      = sense_uv > OC_UV;
    cmp.sense_below_neg_oc = sense_uv < -OC_UV;
    cmp.sense_node_over_sc = node_mv > SC_MV;
    cmp.pack_above_cell    = pack_mv > cell_mv;
    cmp.pack_above_supply  = pack_mv > supply_mv;
    cmp.pack_below_tp      = pack_mv < supply_mv - TP_MV;
    cmp.pack_above_tp      = pack_mv > supply_mv - TP_MV;
    cmp.supply_above_2v2   = supply_mv > 16'sh0898;
    cmp.supply_below_3v    = supply_mv < 16'sh0bb8;
  end
endmodule // cppm_cell_model
`default_nettype wire

//--- sim/tb_cppm_ctrl.sv
// Self-checking testbench for the power-mode and protection controller.
`default_nettype none
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[ERR] %0t mismatch got %h want %h", $time, got, exp); \
    end \
  end
module tb_cppm_ctrl
  import cppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DISC = 20;
  localparam int OVC  = 4;
  localparam int UVC  = 4;
  localparam int OCC  = 3;
  localparam int SCC  = 2;

  logic clk_sys = 1'b0;
  logic reset, host_data_line, power_switch_n, swap_cmd;
  logic disconnect_sleep_en, swap_enable;
  logic charge_enable_bit, discharge_enable_bit;
  logic charge_ctrl_n, discharge_ctrl_n, active_mode, measure_en;
  logic recovery_charge_en, test_pull_down_en, test_pull_up_en;
  logic charger, load;
  logic signed [15:0] cell_mv, supply_mv, sense_uv, node_mv;
  cppm_flags_t flags;
  cppm_cmp_t   cmp;
  int          bad_count, num_checks, n;
  integer      seed;

  always #12.5 clk_sys = ~clk_sys;

  cppm_ctrl #(.DISC_CYC(DISC), .OV_CYC(OVC), .UV_CYC(UVC), .OC_CYC(OCC),
              .SC_CYC(SCC)) uut (
    .clk_sys(clk_sys), .reset(reset), .cmp(cmp),
    .host_data_line(host_data_line), .power_switch_n(power_switch_n),
    .swap_cmd(swap_cmd), .disconnect_sleep_en(disconnect_sleep_en),
    .swap_enable(swap_enable), .charge_enable_bit(charge_enable_bit),
    .discharge_enable_bit(discharge_enable_bit),
    .charge_ctrl_n(charge_ctrl_n), .discharge_ctrl_n(discharge_ctrl_n),
    .flags(flags), .active_mode(active_mode), .measure_en(measure_en),
    .recovery_charge_en(recovery_charge_en),
    .test_pull_down_en(test_pull_down_en), .test_pull_up_en(test_pull_up_en));

  cppm_cell_model u_model (
    .cell_mv(cell_mv), .supply_mv(supply_mv), .sense_uv(sense_uv),
    .node_mv(node_mv), .charger(charger), .load(load),
    .discharge_ctrl_n(discharge_ctrl_n),
    .test_pull_down_en(test_pull_down_en),
    .test_pull_up_en(test_pull_up_en), .cmp(cmp));

  // ---------------------------------------------------------------------
  // Expectations and helpers
  // ---------------------------------------------------------------------
  function automatic logic [1:0] exp_gates(logic act, cppm_flags_t f);
    exp_gates[1] = f.overvoltage_flag | f.undervoltage_flag |
                   f.charge_overcurrent_flag | !charge_enable_bit | !act;
    exp_gates[0] = f.undervoltage_flag | f.charge_overcurrent_flag |
                   f.discharge_overcurrent_flag | !discharge_enable_bit |
                   !act;
  endfunction

  task automatic step(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic expect_st(logic act, logic [3:0] f);
    logic [1:0] g;
    g = exp_gates(act, cppm_flags_t'(f));
    `CHK(active_mode, act)
    `CHK(measure_en, act)
    `CHK(flags, cppm_flags_t'(f))
    `CHK({charge_ctrl_n, discharge_ctrl_n}, g)
  endtask

  // The trip must land exactly one edge after the full delay count.
  task automatic trip(int dly, logic act, logic [3:0] f);
    step(dly);
    expect_st(1'b1, 4'h0);
    step(1);
    expect_st(act, f);
  endtask

  task automatic pulse_swap;
    @(posedge clk_sys);
    swap_cmd <= 1'b1;
    @(posedge clk_sys);
    swap_cmd <= 1'b0;
    #1;
  endtask

  task automatic finish_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    finish_test;
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    seed = 4;
    bad_count = 0;
    num_checks = 0;
    reset = 1'b1;
    host_data_line = 1'b1;
    power_switch_n = 1'b1;
    swap_cmd = 1'b0;
    disconnect_sleep_en = 1'b0;
    swap_enable = 1'b0;
    charge_enable_bit = 1'b1;
    discharge_enable_bit = 1'b1;
    cell_mv = 16'sh0e74;
    supply_mv = 16'sh0e74;
    sense_uv = 16'sh0000;
    node_mv = 16'sh0000;
    charger = 1'b0;
    load = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    step(1);
    expect_st(1'b0, 4'h0);
    @(posedge clk_sys); cell_mv <= 16'sh1130;
    step(OVC + 3);
    expect_st(1'b0, 4'h0);
    @(posedge clk_sys); cell_mv <= 16'sh0e74; power_switch_n <= 1'b0;
    @(posedge clk_sys); power_switch_n <= 1'b1;
    #1;
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); cell_mv <= 16'sh1130;
    trip(OVC, 1'b1, 4'h8);
    @(posedge clk_sys); cell_mv <= 16'sh0e74;
    step(1);
    expect_st(1'b1, 4'h0);
    // Random bursts of 1 to OVC cycles, never past the full delay count, must never trip.
    for (int i = 0; i < 20; i++) begin
      n = 1 + ($unsigned($random(seed)) % OVC);
      @(posedge clk_sys); cell_mv <= 16'sh1130;
      sense_uv <= 16'($random(seed) % 32'sh00000fa0);
      repeat (n - 1) @(posedge clk_sys);
      @(posedge clk_sys); cell_mv <= 16'sh1068;
      node_mv <= 16'($random(seed) % 32'sh00000096);
    end
    step(1);
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); charge_enable_bit <= 1'b0; sense_uv <= 16'sh0000;
    step(1);
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); charge_enable_bit <= 1'b1;
    discharge_enable_bit <= 1'b0;
    step(1);
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); discharge_enable_bit <= 1'b1; node_mv <= 16'sh0000;
    charger <= 1'b1; sense_uv <= 16'sh1770;
    trip(OCC, 1'b1, 4'h2);
    `CHK(test_pull_down_en, 1'b1)
    @(posedge clk_sys); sense_uv <= 16'sh0000;
    step(3);
    expect_st(1'b1, 4'h2);
    @(posedge clk_sys); charger <= 1'b0;
    step(2);
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); load <= 1'b1; sense_uv <= -16'sh1770;
    trip(OCC, 1'b1, 4'h1);
    `CHK(test_pull_up_en, 1'b1)
    @(posedge clk_sys); sense_uv <= 16'sh0000;
    step(3);
    expect_st(1'b1, 4'h1);
    @(posedge clk_sys); load <= 1'b0;
    step(2);
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); load <= 1'b1; node_mv <= 16'sh012c;
    trip(SCC, 1'b1, 4'h1);
    `CHK(test_pull_up_en, 1'b1)
    @(posedge clk_sys); node_mv <= 16'sh0000;
    step(3);
    expect_st(1'b1, 4'h1);
    @(posedge clk_sys); load <= 1'b0;
    step(2);
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); cell_mv <= 16'sh0960;
    trip(UVC, 1'b0, 4'h4);
    @(posedge clk_sys); supply_mv <= 16'sh07d0; cell_mv <= 16'sh07d0;
    charger <= 1'b1;
    step(4);
    expect_st(1'b0, 4'h4);
    `CHK(recovery_charge_en, 1'b1)
    @(posedge clk_sys); supply_mv <= 16'sh0e10; cell_mv <= 16'sh0e10;
    step(2);
    expect_st(1'b1, 4'h0);
    `CHK(recovery_charge_en, 1'b0)
    @(posedge clk_sys); charger <= 1'b0; swap_enable <= 1'b1;
    pulse_swap;
    expect_st(1'b0, 4'h0);
    pulse_swap;
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); swap_enable <= 1'b0;
    pulse_swap;
    expect_st(1'b1, 4'h0);
    @(posedge clk_sys); disconnect_sleep_en <= 1'b1; host_data_line <= 1'b0;
    step(DISC);
    expect_st(1'b1, 4'h0);
    step(1);
    expect_st(1'b0, 4'h0);
    @(posedge clk_sys); host_data_line <= 1'b1;
    step(1);
    expect_st(1'b1, 4'h0);
    finish_test;
  end
endmodule // tb_cppm_ctrl
`undef CHK
`default_nettype wire
